/* File: include/fss_pkg.sv */
// Shared constants and types for the shifter slice host
package fss_pkg;
  // Slice geometry
  localparam int SLICE_W = 4;
  localparam int LINK_W = 3;
  localparam int SLICES = 4;
  localparam int WORD_W = SLICE_W * SLICES;
  localparam int LINKS_W = LINK_W * SLICES;
  localparam int SEL_W = 2;
  localparam int AMT_W = 3;
  // Pre-shift applied to the upper bank of slices
  localparam int BANK_SPAN = 4;
  // Fill bits needed below the word: span plus the link depth
  localparam int FILL_W = BANK_SPAN + LINK_W;
  // Slice settle time and the clock period
  localparam int SETTLE_NS = 11;
  localparam int CLK_PERIOD_NS = 100;
  // Least time rounds up, never below one cycle
  localparam int SETTLE_RAW = (SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int SETTLE_CYC = (SETTLE_RAW < 1) ? 1 : SETTLE_RAW;
  localparam int CNT_W = 4;
  // Values after reset
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [LINKS_W-1:0] LINKS_RST = 12'h000;
  localparam logic [SEL_W-1:0] SEL_RST = 2'h0;
  localparam logic [CNT_W-1:0] CNT_RST = 4'h0;
  localparam logic OE_N_RST = 1'b1;
  // Expected drive-valid patterns
  localparam logic [SLICES-1:0] DV_ALL = 4'hF;
  localparam logic [SLICES-1:0] DV_NONE = 4'h0;

  // How the bits below the word are filled
  typedef enum logic [1:0] {
    FSS_FILL_ZERO = 2'h0,
    FSS_FILL_SIGN = 2'h1,
    FSS_FILL_ROT = 2'h2
  } fss_fill_e;

  // Host sequencing states
  typedef enum logic [2:0] {
    FSS_IDLE = 3'h1,
    FSS_DRIVE = 3'h2,
    FSS_RESP = 3'h4
  } fss_state_e;
endpackage

/* File: include/fss_pins_if.sv */
// Pin bundle for one bank of cascaded shifter slices
`timescale 1ns/100ps
`default_nettype none
interface fss_pins_if;
  // Data nibbles for every slice, slice 0 lowest
  logic [fss_pkg::WORD_W-1:0] data;
  // Three link bits per slice, bit 2 of each group is position -1
  logic [fss_pkg::LINKS_W-1:0] link;
  modport drv (output data, output link);
  modport mon (input data, input link);
endinterface
`default_nettype wire

/* File: hw/fss_bank_drive.sv */
// Data and link pin values for one bank of slices
`timescale 1ns/100ps
`default_nettype none
module fss_bank_drive #(
  parameter bit BANK = 1'b0
) (
  // Word and fill choice
  input wire logic [fss_pkg::WORD_W-1:0] word,
  input wire logic [1:0] mode,
  // Pin values for the bank
  fss_pins_if.drv pins
);
  // Fill bits below position 0, top bit first
  logic [fss_pkg::FILL_W-1:0] fill;
  // Word as the bank sees it, pre-shifted for the upper bank
  logic [fss_pkg::WORD_W-1:0] pre;
  // Fill just under the lowest slice
  logic [fss_pkg::LINK_W-1:0] low;
  // Pre-shifted word with its three low link bits appended
  logic [fss_pkg::WORD_W+fss_pkg::LINK_W-1:0] ext;

  // Zeros, replicated sign bit or the word's own top bits
  assign fill = (mode == fss_pkg::FSS_FILL_ROT) ?
                word[fss_pkg::WORD_W-1 -: fss_pkg::FILL_W] :
                (mode == fss_pkg::FSS_FILL_SIGN) ?
                {fss_pkg::FILL_W{word[0]}} :
                {fss_pkg::FILL_W{1'b0}};

  // Upper bank starts four places higher so its range is 4 to 7
  assign pre = BANK ?
               {word[fss_pkg::WORD_W-fss_pkg::BANK_SPAN-1:0],
                fill[fss_pkg::FILL_W-1 -: fss_pkg::BANK_SPAN]} :
               word;
  // Lowest links tie to zero in zero mode, else follow the fill
  assign low = BANK ? fill[fss_pkg::LINK_W-1:0] :
               fill[fss_pkg::FILL_W-1 -: fss_pkg::LINK_W];
  assign ext = {pre, low};

  // Slices 1 to 3 link to the three top bits of the slice below, slice 0 to the fill
  generate
    for (genvar i = 0; i < fss_pkg::SLICES; i++) begin : g_slice
      assign pins.data[i*fss_pkg::SLICE_W +: fss_pkg::SLICE_W] =
        pre[i*fss_pkg::SLICE_W +: fss_pkg::SLICE_W];
      assign pins.link[i*fss_pkg::LINK_W +: fss_pkg::LINK_W] =
        ext[i*fss_pkg::SLICE_W +: fss_pkg::LINK_W];
    end
  endgenerate
endmodule // fss_bank_drive
`default_nettype wire

/* File: hw/fss_shift_host.sv */
// Host that runs two banks of shifter slices as a 16-bit shifter
`timescale 1ns/100ps
`default_nettype none
module fss_shift_host (
  // Clock and reset
  input wire logic ref_clk,
  input wire logic nrst,
  // Shift request
  input wire logic req_valid,
  output logic req_ready,
  input wire logic [fss_pkg::WORD_W-1:0] req_word,
  input wire logic [fss_pkg::AMT_W-1:0] req_amount,
  input wire logic [1:0] req_mode,
  // Shift answer
  output logic resp_valid,
  output logic [fss_pkg::WORD_W-1:0] resp_word,
  output logic resp_fault,
  // Common select to all slices
  output logic shift_amount_lsb,
  output logic shift_amount_msb,
  // Lower bank pins, shifts 0 to 3
  output logic [fss_pkg::WORD_W-1:0] b0_data,
  output logic [fss_pkg::LINKS_W-1:0] b0_link,
  output logic b0_oe_n,
  // Upper bank pins, shifts 4 to 7
  output logic [fss_pkg::WORD_W-1:0] b1_data,
  output logic [fss_pkg::LINKS_W-1:0] b1_link,
  output logic b1_oe_n,
  // Shared result bus and per-slice drive-valid
  input wire logic [fss_pkg::WORD_W-1:0] result_in,
  input wire logic [fss_pkg::SLICES-1:0] b0_drive_valid,
  input wire logic [fss_pkg::SLICES-1:0] b1_drive_valid
);
  // Sequencing state
  fss_pkg::fss_state_e state_reg, state_next;
  // Settle counter while the slices resolve
  logic [fss_pkg::CNT_W-1:0] cnt_reg, cnt_next;
  // Pin registers
  logic [fss_pkg::WORD_W-1:0] b0_data_reg, b1_data_reg;
  logic [fss_pkg::LINKS_W-1:0] b0_link_reg, b1_link_reg;
  logic [fss_pkg::SEL_W-1:0] sel_reg;
  logic b0_oe_n_reg, b1_oe_n_reg;
  // Answer registers
  logic [fss_pkg::WORD_W-1:0] resp_word_reg;
  logic resp_fault_reg;
  // Pin values from the bank drivers
  fss_pins_if b0_if ();
  fss_pins_if b1_if ();
  // Decoded conditions
  wire accept;
  wire settled;
  wire use_upper;
  wire dv_fault;

  fss_bank_drive #(.BANK(1'b0)) u_bank0 (
    .word(req_word),
    .mode(req_mode),
    .pins(b0_if)
  );
  fss_bank_drive #(.BANK(1'b1)) u_bank1 (
    .word(req_word),
    .mode(req_mode),
    .pins(b1_if)
  );

  // Ready only when idle, so one shift is in flight at a time
  assign req_ready = (state_reg == fss_pkg::FSS_IDLE);
  assign accept = req_valid && req_ready;
  assign use_upper = req_amount[fss_pkg::AMT_W-1];
  // Combinational slices settle within a fixed time
  assign settled = (cnt_reg ==
                    4'(fss_pkg::SETTLE_CYC - 1));
  // Enabled bank must show all valid, the floated bank none
  assign dv_fault = b0_oe_n ?
    (b0_drive_valid != fss_pkg::DV_NONE ||
     b1_drive_valid != fss_pkg::DV_ALL) :
    (b0_drive_valid != fss_pkg::DV_ALL ||
     b1_drive_valid != fss_pkg::DV_NONE);

  // Next state and counter
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    unique case (state_reg)
      // Wait for a request
      fss_pkg::FSS_IDLE: begin
        cnt_next = fss_pkg::CNT_RST;
        if (accept) begin
          state_next = fss_pkg::FSS_DRIVE;
        end
      end
      // Hold pins until the slices settle
      fss_pkg::FSS_DRIVE: begin
        cnt_next = cnt_reg + 4'h1;
        if (settled) begin
          state_next = fss_pkg::FSS_RESP;
        end
      end
      // One-cycle answer
      fss_pkg::FSS_RESP: begin
        state_next = fss_pkg::FSS_IDLE;
      end
      // Illegal codes recover to idle
      default: begin
        state_next = fss_pkg::FSS_IDLE;
      end
    endcase
  end

  // State registers
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      state_reg <= fss_pkg::FSS_IDLE;
      cnt_reg <= fss_pkg::CNT_RST;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
    end
  end

  // Data and select pins load on accept and then hold steady
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      b0_data_reg <= fss_pkg::WORD_RST;
      b1_data_reg <= fss_pkg::WORD_RST;
      b0_link_reg <= fss_pkg::LINKS_RST;
      b1_link_reg <= fss_pkg::LINKS_RST;
      sel_reg <= fss_pkg::SEL_RST;
    end else if (accept) begin
      b0_data_reg <= b0_if.data;
      b1_data_reg <= b1_if.data;
      b0_link_reg <= b0_if.link;
      b1_link_reg <= b1_if.link;
      sel_reg <= req_amount[fss_pkg::SEL_W-1:0];
    end
  end

  // Enables act as the third select bit; both off when idle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      b0_oe_n_reg <= fss_pkg::OE_N_RST;
      b1_oe_n_reg <= fss_pkg::OE_N_RST;
    end else if (accept) begin
      b0_oe_n_reg <= use_upper;
      b1_oe_n_reg <= !use_upper;
    end else if (state_reg == fss_pkg::FSS_DRIVE && settled) begin
      b0_oe_n_reg <= fss_pkg::OE_N_RST;
      b1_oe_n_reg <= fss_pkg::OE_N_RST;
    end
  end

  // Capture the shared bus on the last settle cycle
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      resp_word_reg <= fss_pkg::WORD_RST;
      resp_fault_reg <= 1'b0;
    end else if (state_reg == fss_pkg::FSS_DRIVE && settled) begin
      resp_word_reg <= result_in;
      resp_fault_reg <= dv_fault;
    end
  end

  // Outputs
  assign resp_valid = (state_reg == fss_pkg::FSS_RESP);
  assign resp_word = resp_word_reg;
  assign resp_fault = resp_fault_reg;
  assign shift_amount_lsb = sel_reg[0];
  assign shift_amount_msb = sel_reg[1];
  assign b0_data = b0_data_reg;
  assign b1_data = b1_data_reg;
  assign b0_link = b0_link_reg;
  assign b1_link = b1_link_reg;
  assign b0_oe_n = b0_oe_n_reg;
  assign b1_oe_n = b1_oe_n_reg;

  // Checks on the pins this host drives
  localparam int RESP_D = fss_pkg::SETTLE_CYC + 1;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst);

  a_one_bank_on: assert property (
    state_reg == fss_pkg::FSS_DRIVE |-> b0_oe_n != b1_oe_n)
    else $error("not exactly one bank enabled");
  a_idle_banks_off: assert property (
    state_reg == fss_pkg::FSS_IDLE |-> b0_oe_n && b1_oe_n)
    else $error("bank enabled while idle");
  a_answer_timing: assert property (
    accept |-> ##RESP_D resp_valid)
    else $error("answer not on time");
  a_zero_low_links: assert property (
    accept && req_mode == fss_pkg::FSS_FILL_ZERO |=>
    b0_link[fss_pkg::LINK_W-1:0] == 3'h0 && b1_data[3:0] == 4'h0)
    else $error("zero backfill links not low");
  a_link_cascade: assert property (
    state_reg == fss_pkg::FSS_DRIVE |->
    b0_link[5:3] == b0_data[3:1] && b1_link[11:9] == b1_data[11:9])
    else $error("links not from lower slice");
  a_rotate_fill: assert property (
    accept && req_mode == fss_pkg::FSS_FILL_ROT |=>
    b0_link[2:0] == $past(req_word[15:13]))
    else $error("end-around fill wrong");
  a_select_amount: assert property (
    accept |=> {shift_amount_msb, shift_amount_lsb} ==
    $past(req_amount[1:0]) && b0_oe_n == $past(req_amount[2]))
    else $error("select does not match amount");

  c_upper_bank: cover property (accept && use_upper ##RESP_D resp_valid);
  c_sign_fill: cover property (accept &&
    req_mode == fss_pkg::FSS_FILL_SIGN);
  c_rotate_fill: cover property (accept &&
    req_mode == fss_pkg::FSS_FILL_ROT);
  c_fault_seen: cover property (resp_valid && resp_fault);
endmodule // fss_shift_host
`default_nettype wire

/* File: testbench/fss_slice_bank_model.sv */
// Behavioural model of one bank of four cascaded shifter slices
`timescale 1ns/100ps
`default_nettype none
module fss_slice_bank_model (
  // Slice pins from the host
  input wire logic [15:0] data,
  input wire logic [11:0] link,
  input wire logic sel_lsb,
  input wire logic sel_msb,
  input wire logic oe_n,
  // Test hook: drive-valid stuck low
  input wire logic break_dv,
  // Slice outputs
  output wire logic [15:0] result,
  output logic [3:0] drive_valid
);
  // Common shift amount
  logic [1:0] amt;
  // Unfloated outputs of all slices
  logic [15:0] raw;
  assign amt = {sel_msb, sel_lsb};
  // Each slice sees its links below its own nibble
  for (genvar i = 0; i < 4; i++) begin : g_slice
    // Positions -3..-1 then 0..3
    logic [6:0] ext;
    assign ext = {data[4*i +: 4], link[3*i +: 3]};
    assign raw[4*i +: 4] = ext[3'h3 - {1'b0, amt} +: 4];
  end
  // Floated while disabled, so nothing stale reaches the bus
  assign result = oe_n ? 16'hZZZZ : raw;
  // Drive-valid mirrors the enable unless the fault hook is set
  assign drive_valid = (oe_n || break_dv) ? 4'h0 : 4'hF;
endmodule // fss_slice_bank_model
`default_nettype wire

/* File: testbench/fss_shift_host_tb.sv */
// Self-checking bench for the 16-bit slice shifter host
`timescale 1ns/100ps
`default_nettype none
module fss_shift_host_tb;
  // Clock, reset and tallies
  logic ref_clk = 1'b0;
  logic nrst = 1'b0;
  int errors = 0;
  int cmp_count = 0;
  // Request side
  logic req_valid = 1'b0;
  logic [15:0] req_word = 16'h0000;
  logic [2:0] req_amount = 3'h0;
  logic [1:0] req_mode = 2'h0;
  logic break_dv = 1'b0;
  // Answer and slice pins
  logic req_ready, resp_valid, resp_fault, sel_l, sel_m, b0_oe_n, b1_oe_n;
  logic [15:0] resp_word, b0_data, b1_data, result_in;
  logic [15:0] idle_pat = 16'hA5A5;
  logic [11:0] b0_link, b1_link;
  logic [3:0] dv0, dv1;
  wire logic [15:0] r0;
  wire logic [15:0] r1;

  // Clock generator
  always #50 ref_clk = ~ref_clk;
  // Idle bus toggles so a stale value never passes for a result
  always @(posedge ref_clk) idle_pat <= ~idle_pat;
  // Shared bus: only the enabled bank reaches the host
  assign result_in = !b0_oe_n ? r0 : (!b1_oe_n ? r1 : idle_pat);

  fss_shift_host dut (.ref_clk(ref_clk), .nrst(nrst),
    .req_valid(req_valid), .req_ready(req_ready), .req_word(req_word),
    .req_amount(req_amount), .req_mode(req_mode),
    .resp_valid(resp_valid), .resp_word(resp_word),
    .resp_fault(resp_fault), .shift_amount_lsb(sel_l),
    .shift_amount_msb(sel_m), .b0_data(b0_data), .b0_link(b0_link),
    .b0_oe_n(b0_oe_n), .b1_data(b1_data), .b1_link(b1_link),
    .b1_oe_n(b1_oe_n), .result_in(result_in), .b0_drive_valid(dv0),
    .b1_drive_valid(dv1));
  fss_slice_bank_model m0 (.data(b0_data), .link(b0_link),
    .sel_lsb(sel_l), .sel_msb(sel_m), .oe_n(b0_oe_n),
    .break_dv(break_dv), .result(r0), .drive_valid(dv0));
  fss_slice_bank_model m1 (.data(b1_data), .link(b1_link),
    .sel_lsb(sel_l), .sel_msb(sel_m), .oe_n(b1_oe_n),
    .break_dv(break_dv), .result(r1), .drive_valid(dv1));

  // Compare and tally
  task automatic check(input string name, input logic [15:0] seen,
                       input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask

  // Verdict and end of run
  task automatic wrap_up;
    if (errors == 0 && cmp_count > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // Shift up with the chosen fill entering from below
  function automatic logic [15:0] expect_word(input logic [15:0] w,
      input logic [2:0] a, input logic [1:0] m);
    logic [31:0] ext;
    ext = {w, 16'h0000};
    if (m == 2'h2) ext[15:0] = w;
    if (m == 2'h1 && w[0]) ext[15:0] = 16'hFFFF;
    ext = ext << a;
    return ext[31:16];
  endfunction

  // One request, pin checks in the drive cycle, answer two cycles on
  task automatic do_shift(input logic [15:0] w, input logic [2:0] a,
                          input logic [1:0] m, input logic flt);
    int n;
    n = 0;
    @(posedge ref_clk);
    req_valid <= 1'b1;
    req_word <= w;
    req_amount <= a;
    req_mode <= m;
    do begin
      @(negedge ref_clk);
      n++;
    end while (req_ready !== 1'b1 && n < 20);
    @(posedge ref_clk);
    req_valid <= 1'b0;
    @(negedge ref_clk);
    check("oe_pair", {b1_oe_n, b0_oe_n}, a[2] ? 2'h1 : 2'h2);
    check("select", {sel_m, sel_l}, a[1:0]);
    check("resp_early", resp_valid, 1'b0);
    for (int i = 1; i < 4; i++) begin
      check("cascade", b0_link[3*i +: 3], b0_data[4*i-3 +: 3]);
    end
    check("fill_link", b0_link[2:0], m == 2'h1 ? {3{w[0]}} :
          (m == 2'h2 ? w[15:13] : 3'h0));
    @(negedge ref_clk);
    check("resp_valid", resp_valid, 1'b1);
    check("resp_word", resp_word, expect_word(w, a, m));
    check("resp_fault", resp_fault, flt);
  endtask

  // Idle state straight after reset
  task automatic test_reset;
    @(negedge ref_clk);
    check("ready", req_ready, 1'b1);
    check("oe_idle", {b1_oe_n, b0_oe_n}, 2'h3);
    check("resp_idle", resp_valid, 1'b0);
  endtask

  // Every mode and amount, both sign-bit values
  task automatic test_shifts;
    for (int m = 0; m < 4; m++) begin
      for (int a = 0; a < 8; a++) begin
        do_shift(16'hB4C1, 3'(a), 2'(m), 1'b0);
        do_shift(16'h6A5E, 3'(a), 2'(m), 1'b0);
      end
    end
  endtask

  // Broken drive-valid is flagged, then clears on the next request
  task automatic test_fault;
    @(posedge ref_clk);
    break_dv <= 1'b1;
    do_shift(16'h3C96, 3'h5, 2'h0, 1'b1);
    // Clear the hook on a rising edge, like every other stimulus
    @(posedge ref_clk);
    break_dv <= 1'b0;
    do_shift(16'h3C96, 3'h2, 2'h2, 1'b0);
  endtask

  // Main sequence
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    test_reset();
    test_shifts();
    test_fault();
    wrap_up();
  end

  // Watchdog: about 210 cycles expected, cut at 3000
  initial begin
    #(3000 * 100);
    errors++;
    wrap_up();
  end
endmodule // fss_shift_host_tb
`default_nettype wire
